/* File: logic/ssp_prog_regs.sv */
// Serial programming port and its reference and receive frequency registers.
//
// Contract
// - Programming uses three wires: serial clock, latch strobe and data.
// - Every transfer carries a 23-bit word.
// - Two lowest word bits select ref, rx, tx or mode register.
// - Data shifts in on rising serial clock only while strobe is high.
// - Strobe falling edge copies the word into the selected register.
// - That copy is not aligned to divider counting.
// - Select 00 targets reference register; last bit shifted is bit 1.
// - Reference bits 3 to 13 form an 11-bit divide count.
// - Internal reference equals oscillator divided by the divide count.
// - Bandwidth divisor is 580 times ratio; IF divisor 544 times ratio.
// - Bit 1 set, bit 2 clear targets the receive register.
// - Receive bits 3 to 5 hold the fractional count.
// - Receive bits 6 to 10 hold the swallow count.
// - Receive bits 11 to 20 hold the main count.
// - Receive ratio is 32 times main plus swallow plus fraction eighths.
// - Bit 1 clear, bit 2 set targets the transmit register.
`timescale 1ns/100ps
module ssp_prog_regs
(
	input  wire logic                                clk_sys,
	input  wire logic                                reset,
	input  wire logic                                sclk,
	input  wire logic                                latch_strobe,
	input  wire logic                                sdata,
	output logic      [ssp_pkg::REF_DIV_W-1:0]       ref_divide_count,
	output logic      [ssp_pkg::DEMOD_SEL_W-1:0]     demod_ratio_sel,
	output logic      [ssp_pkg::DEMOD_RATIO_W-1:0]   demod_ratio,
	output logic      [ssp_pkg::DIVISOR_W-1:0]       demod_bandwidth_div,
	output logic      [ssp_pkg::DIVISOR_W-1:0]       if_div,
	output logic                                     ref_tick,
	output logic      [ssp_pkg::RX_FRAC_W-1:0]       rx_frac_count,
	output logic      [ssp_pkg::RX_SWALLOW_W-1:0]    rx_swallow_count,
	output logic      [ssp_pkg::RX_MAIN_W-1:0]       rx_main_count,
	output logic      [ssp_pkg::RX_TRIM_W-1:0]       rx_trim,
	output logic      [ssp_pkg::RX_RATIO_W-1:0]      rx_ratio_x8,
	output logic      [ssp_pkg::TX_PAYLOAD_W-1:0]    tx_word,
	output logic      [ssp_pkg::MODE_PAYLOAD_W-1:0]  mode_word,
	output logic                                     load_pulse,
	output logic      [ssp_pkg::SEL_W-1:0]           load_sel
);
	import ssp_pkg::*;

	logic [WORD_W-1:0] shift_word;
	logic              strobe_meta;
	logic              strobe_sync;
	logic              strobe_prev;
	logic              strobe_fall;
	ssp_sel_e          word_sel;

	// The serial clock owns the shift register; nothing else writes it.
	ssp_shifter u_shifter
	(
		.sclk         (sclk),
		.latch_strobe (latch_strobe),
		.sdata        (sdata),
		.shift_word   (shift_word)
	);

	// The strobe is a pin: two flops before any system-clock logic looks at it.
	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			strobe_meta <= 1'b0;
		end
		else
		begin
			strobe_meta <= latch_strobe;
		end
	end

	// Second stage: the only flop allowed to read the possibly metastable first one.
	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			strobe_sync <= 1'b0;
		end
		else
		begin
			strobe_sync <= strobe_meta;
		end
	end

	// The third flop only remembers the settled level for the edge detector.
	// It resets to the idle level of the pin, so no false edge follows reset.
	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			strobe_prev <= 1'b0;
		end
		else
		begin
			strobe_prev <= strobe_sync;
		end
	end

	// The word is read across domains only after the strobe is seen low. It is
	// stable then because shifting needs the strobe high; the controller's lead
	// time before the next word covers the synchroniser delay of a few cycles.
	assign strobe_fall = strobe_prev & ~strobe_sync;
	assign word_sel    = ssp_sel_e'(shift_word[SEL_LSB +: SEL_W]);

	// Every register load waits for the same strobe edge and differs only by select,
	// so the decode lives in one place and all register blocks agree on it.
	function automatic logic ssp_load_hit(input logic fall, input ssp_sel_e sel,
		input ssp_sel_e want);
		logic hit;
		hit = 1'b0;
		if (fall)
		begin
			hit = (sel == want);
		end
		return hit;
	endfunction : ssp_load_hit

	logic hit_ref;
	logic hit_rx;
	logic hit_tx;
	logic hit_mode;

	assign hit_ref  = ssp_load_hit(strobe_fall, word_sel, SSP_SEL_REF);
	assign hit_rx   = ssp_load_hit(strobe_fall, word_sel, SSP_SEL_RX);
	assign hit_tx   = ssp_load_hit(strobe_fall, word_sel, SSP_SEL_TX);
	assign hit_mode = ssp_load_hit(strobe_fall, word_sel, SSP_SEL_MODE);

	// The divisors are needed at reset and in service, so each has one definition.
	function automatic logic [DIVISOR_W-1:0] ssp_bw_div(input logic [DEMOD_SEL_W-1:0] sel);
		logic [DEMOD_RATIO_W-1:0] ratio;
		ratio = ssp_demod_ratio(sel);
		return ssp_scale(BANDWIDTH_MULT, ratio);
	endfunction : ssp_bw_div

	function automatic logic [DIVISOR_W-1:0] ssp_if_div(input logic [DEMOD_SEL_W-1:0] sel);
		logic [DEMOD_RATIO_W-1:0] ratio;
		ratio = ssp_demod_ratio(sel);
		return ssp_scale(IF_MULT, ratio);
	endfunction : ssp_if_div

	// The pulse marks the cycle in which the selected register takes its new value.
	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			load_pulse <= 1'b0;
		end
		else
		begin
			load_pulse <= strobe_fall;
		end
	end

	// The select is kept after the pulse so a slow observer can still read it.
	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			load_sel <= SSP_SEL_REF;
		end
		else if (strobe_fall)
		begin
			load_sel <= word_sel;
		end
	end

	// Reference register: divide count. A zero count is taken as written; the
	// divider treats it as stopped rather than guessing a legal value.
	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			ref_divide_count <= RST_REF_DIV;
		end
		else if (hit_ref)
		begin
			ref_divide_count <= shift_word[REF_DIV_LSB +: REF_DIV_W];
		end
	end

	// Only bits 14 to 16 are taken; higher word bits carry nothing here.
	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			demod_ratio_sel <= RST_DEMOD_SEL;
		end
		else if (hit_ref)
		begin
			demod_ratio_sel <= shift_word[DEMOD_SEL_LSB +: DEMOD_SEL_W];
		end
	end

	// Derived demodulator figures follow the select one cycle later.
	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			demod_ratio <= ssp_demod_ratio(RST_DEMOD_SEL);
		end
		else
		begin
			demod_ratio <= ssp_demod_ratio(demod_ratio_sel);
		end
	end

	// Registering the product keeps the multiplier off the output path.
	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			demod_bandwidth_div <= ssp_bw_div(RST_DEMOD_SEL);
		end
		else
		begin
			demod_bandwidth_div <= ssp_bw_div(demod_ratio_sel);
		end
	end

	// Computed from the select, not from demod_ratio, so all three move together.
	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			if_div <= ssp_if_div(RST_DEMOD_SEL);
		end
		else
		begin
			if_div <= ssp_if_div(demod_ratio_sel);
		end
	end

	// A count of zero is outside the legal range and stops the reference ticks.
	// The divider picks up a new count at once, mid-period if need be.
	ssp_ref_divider u_ref_divider
	(
		.clk_sys      (clk_sys),
		.reset        (reset),
		.divide_count (ref_divide_count),
		.ref_tick     (ref_tick)
	);

	// Receive register fields, each loaded only by a receive word.
	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			rx_frac_count <= RST_RX_FRAC;
		end
		else if (hit_rx)
		begin
			rx_frac_count <= shift_word[RX_FRAC_LSB +: RX_FRAC_W];
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			rx_swallow_count <= RST_RX_SWALLOW;
		end
		else if (hit_rx)
		begin
			rx_swallow_count <= shift_word[RX_SWALLOW_LSB +: RX_SWALLOW_W];
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			rx_main_count <= RST_RX_MAIN;
		end
		else if (hit_rx)
		begin
			rx_main_count <= shift_word[RX_MAIN_LSB +: RX_MAIN_W];
		end
	end

	// Bit 23 has no home in the receive register and is dropped.
	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			rx_trim <= RST_RX_TRIM;
		end
		else if (hit_rx)
		begin
			rx_trim <= shift_word[RX_TRIM_LSB +: RX_TRIM_W];
		end
	end

	// Swallow is below 32 and fraction below 8, so the ratio in eighths is a plain
	// concatenation and needs no adder.
	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			rx_ratio_x8 <= {RST_RX_MAIN, RST_RX_SWALLOW, RST_RX_FRAC};
		end
		else
		begin
			rx_ratio_x8 <= {rx_main_count, rx_swallow_count, rx_frac_count};
		end
	end

	// Transmit and mode registers are held whole for the logic that uses them.
	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			tx_word <= RST_TX_WORD;
		end
		else if (hit_tx)
		begin
			tx_word <= shift_word[PAYLOAD_LSB +: TX_PAYLOAD_W];
		end
	end

	// The mode word keeps bits 3 to 22; bit 23 is unused there.
	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			mode_word <= RST_MODE_WORD;
		end
		else if (hit_mode)
		begin
			mode_word <= shift_word[PAYLOAD_LSB +: MODE_PAYLOAD_W];
		end
	end
endmodule : ssp_prog_regs

/* File: logic/ssp_ref_divider.sv */
// Reference divider producing one tick per programmed count of system clocks.
`timescale 1ns/100ps
module ssp_ref_divider
(
	input  wire logic                           clk_sys,
	input  wire logic                           reset,
	input  wire logic [ssp_pkg::REF_DIV_W-1:0]  divide_count,
	output logic                                ref_tick
);
	import ssp_pkg::*;

	logic [REF_DIV_W-1:0] count;

	// A new count takes effect at once; a running count past the new end wraps now.
	always_ff @(posedge clk_sys)
	begin
		if (reset || divide_count == RST_REF_DIV)
		begin
			count <= RST_REF_DIV;
		end
		else if (count >= REF_DIV_W'(divide_count - 11'h001))
		begin
			count <= RST_REF_DIV;
		end
		else
		begin
			count <= REF_DIV_W'(count + 11'h001);
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (reset || divide_count == RST_REF_DIV)
		begin
			ref_tick <= 1'b0;
		end
		else
		begin
			ref_tick <= (count >= REF_DIV_W'(divide_count - 11'h001));
		end
	end
endmodule : ssp_ref_divider

/* File: logic/ssp_shifter.sv */
// Serial-clock shift register that assembles the programming word.
`timescale 1ns/100ps
module ssp_shifter
(
	input  wire logic                         sclk,
	input  wire logic                         latch_strobe,
	input  wire logic                         sdata,
	output logic      [ssp_pkg::WORD_W-1:0]   shift_word
);
	import ssp_pkg::*;

	// The strobe is set up ahead of the first clock edge by the controller, so it is
	// sampled here as a qualifier of this domain. Extra bits push the oldest ones out.
	always_ff @(posedge sclk)
	begin
		if (latch_strobe)
		begin
			shift_word <= {shift_word[WORD_W-2:0], sdata};
		end
	end
endmodule : ssp_shifter

/* File: pkg/ssp_pkg.sv */
// Shared constants and types for the serial programming register block.
package ssp_pkg;
	localparam int unsigned WORD_W         = 23;
	localparam int unsigned SEL_LSB        = 0;
	localparam int unsigned SEL_W          = 2;
	localparam int unsigned REF_DIV_LSB    = 2;
	localparam int unsigned REF_DIV_W      = 11;
	localparam int unsigned DEMOD_SEL_LSB  = 13;
	localparam int unsigned DEMOD_SEL_W    = 3;
	localparam int unsigned RX_FRAC_LSB    = 2;
	localparam int unsigned RX_FRAC_W      = 3;
	localparam int unsigned RX_SWALLOW_LSB = 5;
	localparam int unsigned RX_SWALLOW_W   = 5;
	localparam int unsigned RX_MAIN_LSB    = 10;
	localparam int unsigned RX_MAIN_W      = 10;
	localparam int unsigned RX_TRIM_LSB    = 20;
	localparam int unsigned RX_TRIM_W      = 2;
	localparam int unsigned PAYLOAD_LSB    = 2;
	localparam int unsigned TX_PAYLOAD_W   = 21;
	localparam int unsigned MODE_PAYLOAD_W = 20;
	localparam int unsigned RX_RATIO_W     = RX_MAIN_W + RX_SWALLOW_W + RX_FRAC_W;
	localparam int unsigned DEMOD_RATIO_W  = 7;
	localparam int unsigned DIVISOR_W      = 16;
	localparam logic [9:0]  BANDWIDTH_MULT = 10'h244;
	localparam logic [9:0]  IF_MULT        = 10'h220;
	localparam logic [10:0] RST_REF_DIV    = 11'h000;
	localparam logic [2:0]  RST_DEMOD_SEL  = 3'h0;
	localparam logic [2:0]  RST_RX_FRAC    = 3'h0;
	localparam logic [4:0]  RST_RX_SWALLOW = 5'h00;
	localparam logic [9:0]  RST_RX_MAIN    = 10'h000;
	localparam logic [1:0]  RST_RX_TRIM    = 2'h0;
	localparam logic [20:0] RST_TX_WORD    = 21'h000000;
	localparam logic [19:0] RST_MODE_WORD  = 20'h00000;

	typedef enum logic [1:0]
	{
		SSP_SEL_REF  = 2'b00,
		SSP_SEL_RX   = 2'b01,
		SSP_SEL_TX   = 2'b10,
		SSP_SEL_MODE = 2'b11
	} ssp_sel_e;

	function automatic logic [6:0] ssp_demod_ratio(input logic [2:0] code);
		logic [6:0] r;
		r = 7'h02;
		unique case (code)
			3'h0: r = 7'h02;
			3'h1: r = 7'h06;
			3'h2: r = 7'h0c;
			3'h3: r = 7'h18;
			3'h4: r = 7'h24;
			3'h5: r = 7'h30;
			3'h6: r = 7'h48;
			3'h7: r = 7'h60;
		endcase
		return r;
	endfunction : ssp_demod_ratio

	function automatic logic [15:0] ssp_scale(input logic [9:0] mult, input logic [6:0] ratio);
		logic [16:0] p;
		p = 17'(mult * ratio);
		return p[15:0];
	endfunction : ssp_scale
endpackage : ssp_pkg

/* File: verification/ssp_host_model.sv */
// Host controller model driving the three-wire programming bus.
`timescale 1ns/100ps
module ssp_host_model
(
	output	logic	sclk,
	output	logic	latch_strobe,
	output	logic	sdata
);
	initial
	begin
		sclk = 1'b0;
		latch_strobe = 1'b0;
		sdata = 1'b0;
	end

	// The 48 ns serial period leaves 24 ns of setup and hold, tighter than a real part allows.
	task automatic send_word(input logic [22:0] w);
		latch_strobe = 1'b1;
		#30;
		for (int i = 22; i >= 0; i--)
		begin
			sdata = w[i];
			#24 sclk = 1'b1;
			#24 sclk = 1'b0;
		end
		#30 latch_strobe = 1'b0;
		sdata = ~w[0];
	endtask : send_word
endmodule : ssp_host_model

/* File: verification/ssp_prog_checker.sv */
// Concurrent checks on the programming register block outputs.
`timescale 1ns/100ps
module ssp_prog_checker
(
	input	wire logic			clk_sys,
	input	wire logic			reset,
	input	wire logic			latch_strobe,
	input	wire logic [10:0]	ref_divide_count,
	input	wire logic [2:0]	demod_ratio_sel,
	input	wire logic [6:0]	demod_ratio,
	input	wire logic [15:0]	demod_bandwidth_div,
	input	wire logic [15:0]	if_div,
	input	wire logic			ref_tick,
	input	wire logic [2:0]	rx_frac_count,
	input	wire logic [4:0]	rx_swallow_count,
	input	wire logic [9:0]	rx_main_count,
	input	wire logic [17:0]	rx_ratio_x8,
	input	wire logic			load_pulse,
	input	wire logic [1:0]	load_sel
);
	localparam logic [6:0] RT [8] = '{7'h02, 7'h06, 7'h0c, 7'h18, 7'h24, 7'h30, 7'h48, 7'h60};
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);
	a_pulse_single: assert property (load_pulse |=> !load_pulse)
		else $error("load pulse longer than one cycle");
	a_load_after_fall: assert property ($fell(latch_strobe) |-> ##[1:6] load_pulse)
		else $error("no load after strobe fell");
	a_pulse_cause: assert property (load_pulse |-> !latch_strobe && !$past(latch_strobe))
		else $error("load pulse without strobe low");
	a_ref_hold: assert property ($changed({ref_divide_count, demod_ratio_sel})
		|-> load_pulse && load_sel == 2'h0)
		else $error("reference register changed without reference load");
	a_rx_hold: assert property ($changed({rx_main_count, rx_swallow_count, rx_frac_count})
		|-> load_pulse && load_sel == 2'h1)
		else $error("receive register changed without receive load");
	a_ratio_map: assert property (1'b1 |=> demod_ratio == RT[$past(demod_ratio_sel)])
		else $error("demodulator ratio wrong");
	a_div_scale: assert property (demod_bandwidth_div == 16'(580 * demod_ratio)
		&& if_div == 16'(544 * demod_ratio))
		else $error("bandwidth or IF divisor wrong");
	a_rx_ratio: assert property (1'b1 |=> rx_ratio_x8 == {$past(rx_main_count),
		$past(rx_swallow_count), $past(rx_frac_count)})
		else $error("receive ratio wrong");
	a_tick_stop: assert property (ref_divide_count == 0 && $past(ref_divide_count) == 0
		&& $past(ref_divide_count, 2) == 0 |-> !ref_tick)
		else $error("tick while divider stopped");
endmodule : ssp_prog_checker

bind ssp_prog_regs ssp_prog_checker u_chk (.clk_sys, .reset, .latch_strobe, .ref_divide_count,
	.demod_ratio_sel, .demod_ratio, .demod_bandwidth_div, .if_div, .ref_tick, .rx_frac_count,
	.rx_swallow_count, .rx_main_count, .rx_ratio_x8, .load_pulse, .load_sel);

/* File: verification/tb_synth_serial_program_regs.sv */
// Self-checking bench for the serial programming register block.
`timescale 1ns/100ps
module tb_synth_serial_program_regs;
	import ssp_pkg::*;
	logic	clk_sys;
	logic	reset;
	logic	sclk;
	logic	latch_strobe;
	logic	sdata;
	logic [10:0]	ref_divide_count;
	logic [2:0]	demod_ratio_sel;
	logic [6:0]	demod_ratio;
	logic [15:0]	demod_bandwidth_div;
	logic [15:0]	if_div;
	logic	ref_tick;
	logic [2:0]	rx_frac_count;
	logic [4:0]	rx_swallow_count;
	logic [9:0]	rx_main_count;
	logic [1:0]	rx_trim;
	logic [17:0]	rx_ratio_x8;
	logic [20:0]	tx_word;
	logic [19:0]	mode_word;
	logic	load_pulse;
	logic [1:0]	load_sel;
	int	n_errors = 0;
	int	num_checks = 0;
	int	ratios [8] = '{2, 6, 12, 24, 36, 48, 72, 96};

	ssp_host_model u_host (.sclk, .latch_strobe, .sdata);
	ssp_prog_regs u_dut (.clk_sys, .reset, .sclk, .latch_strobe, .sdata, .ref_divide_count,
		.demod_ratio_sel, .demod_ratio, .demod_bandwidth_div, .if_div, .ref_tick,
		.rx_frac_count, .rx_swallow_count, .rx_main_count, .rx_trim, .rx_ratio_x8,
		.tx_word, .mode_word, .load_pulse, .load_sel);

	initial
	begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end

	task automatic chk(input string what, input logic [22:0] exp, input logic [22:0] got);
		num_checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic send(input logic [22:0] w, input logic [1:0] sel);
		int n;
		n = 0;
		u_host.send_word(w);
		while (load_pulse !== 1'b1 && n < 20)
		begin
			@(negedge clk_sys);
			n++;
		end
		chk("load_sel", 23'(sel), 23'(load_sel));
		repeat (2) @(negedge clk_sys);
	endtask : send

	task automatic t_ref_ratios();
		for (int c = 0; c < 8; c++)
		begin
			send({7'h7f, 3'(c), 11'(c + 7), 2'b00}, 2'h0);
			chk("ref_div", 23'(c + 7), 23'(ref_divide_count));
			chk("ratio_sel", 23'(c), 23'(demod_ratio_sel));
			chk("ratio", 23'(ratios[c]), 23'(demod_ratio));
			chk("bw_div", 23'(580 * ratios[c]), 23'(demod_bandwidth_div));
			chk("if_div", 23'(544 * ratios[c]), 23'(if_div));
		end
	endtask : t_ref_ratios

	task automatic t_ref_tick();
		int n;
		send({10'h0, 11'h005, 2'b00}, 2'h0);
		n = 0;
		while (ref_tick !== 1'b1 && n < 20)
		begin
			@(negedge clk_sys);
			n++;
		end
		n = 0;
		do
		begin
			@(negedge clk_sys);
			n++;
		end while (ref_tick !== 1'b1 && n < 20);
		chk("tick_gap", 23'd5, 23'(n));
		send({10'h0, 11'h7ff, 2'b00}, 2'h0);
		chk("ref_div_max", 23'h7ff, 23'(ref_divide_count));
		send(23'h0, 2'h0);
		n = 0;
		repeat (40)
		begin
			@(negedge clk_sys);
			if (ref_tick !== 1'b0)
				n++;
		end
		chk("tick_stop", 23'h0, 23'(n));
	endtask : t_ref_tick

	task automatic t_rx_tx_mode();
		send({1'b1, 2'h2, 10'h234, 5'h16, 3'h5, 2'b01}, 2'h1);
		chk("frac", 23'h5, 23'(rx_frac_count));
		chk("swallow", 23'h16, 23'(rx_swallow_count));
		chk("main", 23'h234, 23'(rx_main_count));
		chk("trim", 23'h2, 23'(rx_trim));
		chk("ratio_x8", 23'(8 * (32 * 'h234 + 'h16) + 5), 23'(rx_ratio_x8));
		chk("ref_kept", 23'h0, 23'(ref_divide_count));
		send(23'h5a5a5a, 2'h2);
		chk("tx", 23'h5a5a5a >> 2, 23'(tx_word));
		send(23'h4c3a57, 2'h3);
		chk("mode", (23'h4c3a57 >> 2) & 23'hfffff, 23'(mode_word));
		chk("rx_kept", 23'h234, 23'(rx_main_count));
	endtask : t_rx_tx_mode

	task automatic tally_and_finish();
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : tally_and_finish

	initial
	begin
		#200000;
		n_errors++;
		tally_and_finish();
	end

	initial
	begin
		reset = 1'b1;
		repeat (8) @(posedge clk_sys);
		reset <= 1'b0;
		repeat (2) @(negedge clk_sys);
		t_ref_ratios();
		t_ref_tick();
		t_rx_tx_mode();
		tally_and_finish();
	end
endmodule : tb_synth_serial_program_regs
